// ===== logic/algo_cfg_pkg.sv
// package: offsets, field positions and reset values of the algorithm configuration bank
package algo_cfg_pkg;
    // ****************************************
    // geometry
    // ****************************************
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int NUM_REGS = 14;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFS_DETECT_CFG     = 12'h080;
    localparam logic [ADDR_W-1:0] OFS_REVERSE_CFG    = 12'h082;
    localparam logic [ADDR_W-1:0] OFS_STARTUP_A      = 12'h084;
    localparam logic [ADDR_W-1:0] OFS_STARTUP_B      = 12'h086;
    localparam logic [ADDR_W-1:0] OFS_LOOP_A         = 12'h088;
    localparam logic [ADDR_W-1:0] OFS_LOOP_B         = 12'h08A;
    localparam logic [ADDR_W-1:0] OFS_LOOP_C         = 12'h08C;
    localparam logic [ADDR_W-1:0] OFS_LOOP_D         = 12'h08E;
    localparam logic [ADDR_W-1:0] OFS_CURVE_A        = 12'h094;
    localparam logic [ADDR_W-1:0] OFS_CURVE_B        = 12'h096;
    localparam logic [ADDR_W-1:0] OFS_CURVE_C        = 12'h098;
    localparam logic [ADDR_W-1:0] OFS_CURVE_D        = 12'h09A;
    localparam logic [ADDR_W-1:0] OFS_CURVE_E        = 12'h09C;
    localparam logic [ADDR_W-1:0] OFS_CURVE_F        = 12'h09E;

    localparam logic [NUM_REGS-1:0][ADDR_W-1:0] REG_OFFSETS = {
        OFS_CURVE_F, OFS_CURVE_E, OFS_CURVE_D, OFS_CURVE_C, OFS_CURVE_B, OFS_CURVE_A,
        OFS_LOOP_D, OFS_LOOP_C, OFS_LOOP_B, OFS_LOOP_A,
        OFS_STARTUP_B, OFS_STARTUP_A, OFS_REVERSE_CFG, OFS_DETECT_CFG};

    localparam int IDX_DETECT_CFG = 0;

    // ****************************************
    // detect configuration word fields
    // ****************************************
    localparam int BIT_RESERVED_TOP      = 31;
    localparam int BIT_SPEED_DETECT_EN   = 30;
    localparam int BIT_DETECT_BRAKE_EN   = 29;
    localparam int BIT_DETECT_COAST_EN   = 28;
    localparam int BIT_REVERSE_DRIVE_EN  = 27;
    localparam int BIT_FORWARD_FORWARD_RESYNC_ENABLE = 26;
    localparam int BIT_BRAKE_METHOD      = 21;

    // ****************************************
    // reset values and masks
    // ****************************************
    localparam logic [DATA_W-1:0] RESET_VALUE   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DETECT_WMASK  = 32'h7FFF_FFFF;
    localparam logic [DATA_W-1:0] DEFAULT_WMASK = 32'hFFFF_FFFF;
    localparam logic [DATA_W-1:0] READ_ZERO     = 32'h0000_0000;
endpackage

// ===== logic/cfg_access_if.sv
// interface: register access signals between the bank and its storage word
`timescale 1ns/1ps
interface cfg_access_if;
    logic                            wrStrobe;
    logic [algo_cfg_pkg::DATA_W-1:0] wrData;
    logic [algo_cfg_pkg::DATA_W-1:0] wrMask;
    logic [algo_cfg_pkg::DATA_W-1:0] value;

    modport master
    (
        output wrStrobe,
        output wrData,
        output wrMask,
        input  value
    );
    modport word
    (
        input  wrStrobe,
        input  wrData,
        input  wrMask,
        output value
    );
endinterface

// ===== logic/cfg_word.sv
// module: one masked configuration storage word
`timescale 1ns/1ps
module cfg_word
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    cfg_access_if.word acc
);
    logic [algo_cfg_pkg::DATA_W-1:0] word_reg;
    logic [algo_cfg_pkg::DATA_W-1:0] word_next;

    // masked bits keep their stored value, so read-only bits stay at reset
    assign word_next = acc.wrStrobe ? ((acc.wrData & acc.wrMask) | (word_reg & ~acc.wrMask))
                                    : word_reg;
    assign acc.value = word_reg;

    // storage flop
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            word_reg <= algo_cfg_pkg::RESET_VALUE;
        else
            word_reg <= word_next;
    end
endmodule // cfg_word

// ===== logic/motor_algorithm_config_regs.sv
// module: algorithm configuration register bank with detect-word control outputs
// ****************************************
// ****************************************
`timescale 1ns/1ps
module motor_algorithm_config_regs
(
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              regWrite,
    input  wire logic                              regRead,
    input  wire logic [algo_cfg_pkg::ADDR_W-1:0]   regAddr,
    input  wire logic [algo_cfg_pkg::DATA_W-1:0]   regWrData,
    output logic      [algo_cfg_pkg::DATA_W-1:0]   regRdData,
    output logic                                   regRdValid,
    output logic                                   regAddrError,
    output logic                                   speedDetectEnable,
    output logic                                   detectBrakeEnable,
    output logic                                   detectCoastEnable,
    output logic                                   reverseDriveEnable,
    output logic                                   forwardResyncEnable,
    output logic                                   brakeAllLowSide
);
    localparam int N = algo_cfg_pkg::NUM_REGS;

    // ****************************************
    // address decode
    // ****************************************
    // one-hot hit vector; reused for write and read selection
    function automatic logic [N-1:0] decode(input logic [algo_cfg_pkg::ADDR_W-1:0] a);
        logic [N-1:0] hit;
        hit = '0;
        for (int i = 0; i < N; i++)
            hit[i] = (a == algo_cfg_pkg::REG_OFFSETS[i]);
        return hit;
    endfunction

    logic [N-1:0]                    hitVec;
    logic                            anyHit;
    logic [N-1:0][algo_cfg_pkg::DATA_W-1:0] values;
    logic [algo_cfg_pkg::DATA_W-1:0] readMux;

    assign hitVec = decode(regAddr);
    assign anyHit = |hitVec;

    // ****************************************
    // storage words
    // ****************************************
    // unlisted offsets hit nothing, so writes there change no stored word
    generate
        for (genvar g = 0; g < N; g++)
        begin : g_word
            cfg_access_if acc();
            assign acc.wrStrobe = regWrite && hitVec[g];
            assign acc.wrData   = regWrData;
            // detect word top bit is read-only zero
            assign acc.wrMask   = (g == algo_cfg_pkg::IDX_DETECT_CFG)
                                ? algo_cfg_pkg::DETECT_WMASK : algo_cfg_pkg::DEFAULT_WMASK;
            assign values[g]    = acc.value;
            cfg_word u_word
            (
                .clk   (clk),
                .rst_n (rst_n),
                .acc   (acc)
            );
        end
    endgenerate

    // ****************************************
    // read path
    // ****************************************
    // and-or mux; unmapped offsets read zero rather than stale data
    always_comb
    begin
        readMux = algo_cfg_pkg::READ_ZERO;
        for (int i = 0; i < N; i++)
            readMux = readMux | (values[i] & {algo_cfg_pkg::DATA_W{hitVec[i]}});
    end

    logic [algo_cfg_pkg::DATA_W-1:0] detectWord;
    assign detectWord = values[algo_cfg_pkg::IDX_DETECT_CFG];

    // registered read answer, one cycle after the request
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regRdData    <= algo_cfg_pkg::READ_ZERO;
            regRdValid   <= 1'b0;
            regAddrError <= 1'b0;
        end
        else
        begin
            regRdData    <= regRead ? readMux : algo_cfg_pkg::READ_ZERO;
            regRdValid   <= regRead;
            regAddrError <= (regRead || regWrite) && !anyHit;
        end
    end

    // ****************************************
    // control outputs from the detect word
    // ****************************************
    // registered copies so every output comes from a flop; one cycle behind storage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            speedDetectEnable   <= 1'b0;
            detectBrakeEnable   <= 1'b0;
            detectCoastEnable   <= 1'b0;
            reverseDriveEnable  <= 1'b0;
            forwardResyncEnable <= 1'b0;
            brakeAllLowSide     <= 1'b0;
        end
        else
        begin
            speedDetectEnable   <= detectWord[algo_cfg_pkg::BIT_SPEED_DETECT_EN];
            detectBrakeEnable   <= detectWord[algo_cfg_pkg::BIT_DETECT_BRAKE_EN];
            detectCoastEnable   <= detectWord[algo_cfg_pkg::BIT_DETECT_COAST_EN];
            reverseDriveEnable  <= detectWord[algo_cfg_pkg::BIT_REVERSE_DRIVE_EN];
            forwardResyncEnable <= detectWord[algo_cfg_pkg::BIT_FORWARD_FORWARD_RESYNC_ENABLE];
            brakeAllLowSide     <= detectWord[algo_cfg_pkg::BIT_BRAKE_METHOD];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    // a write to the detect word lands with its top bit cleared
    a_detect_write_read: assert property (@(posedge clk) disable iff (!rst_n)
        regWrite && regAddr == algo_cfg_pkg::OFS_DETECT_CFG
        |=> detectWord == ($past(regWrData) & algo_cfg_pkg::DETECT_WMASK))
        else $error("detect word write did not land");

    // a read returns the stored word; a same-cycle write is not seen yet
    a_detect_readback: assert property (@(posedge clk) disable iff (!rst_n)
        regRead && regAddr == algo_cfg_pkg::OFS_DETECT_CFG
        |=> regRdValid && regRdData == $past(detectWord))
        else $error("detect word readback wrong");

    // the reserved top bit never reaches a read answer
    a_top_bit_zero: assert property (@(posedge clk) disable iff (!rst_n)
        regRdValid && $past(regAddr) == algo_cfg_pkg::OFS_DETECT_CFG
        |-> !regRdData[algo_cfg_pkg::BIT_RESERVED_TOP])
        else $error("reserved top bit read as one");

    // the stored top bit stays clear whatever the host writes
    a_top_bit_store: assert property (@(posedge clk) disable iff (!rst_n)
        !detectWord[algo_cfg_pkg::BIT_RESERVED_TOP])
        else $error("reserved top bit stored as one");

    // detect enable follows its written bit two edges after the write
    a_detect_enable: assert property (@(posedge clk) disable iff (!rst_n)
        regWrite && regAddr == algo_cfg_pkg::OFS_DETECT_CFG
        |=> ##1 speedDetectEnable == $past(regWrData[algo_cfg_pkg::BIT_SPEED_DETECT_EN], 2))
        else $error("detect enable not following bit");

    // brake enable follows its written bit two edges after the write
    a_brake_enable: assert property (@(posedge clk) disable iff (!rst_n)
        regWrite && regAddr == algo_cfg_pkg::OFS_DETECT_CFG
        |=> ##1 detectBrakeEnable == $past(regWrData[algo_cfg_pkg::BIT_DETECT_BRAKE_EN], 2))
        else $error("brake enable not following bit");

    // coast enable follows its written bit two edges after the write
    a_coast_enable: assert property (@(posedge clk) disable iff (!rst_n)
        regWrite && regAddr == algo_cfg_pkg::OFS_DETECT_CFG
        |=> ##1 detectCoastEnable == $past(regWrData[algo_cfg_pkg::BIT_DETECT_COAST_EN], 2))
        else $error("coast enable not following bit");

    // reverse drive enable follows its written bit two edges after the write
    a_reverse_enable: assert property (@(posedge clk) disable iff (!rst_n)
        regWrite && regAddr == algo_cfg_pkg::OFS_DETECT_CFG
        |=> ##1 reverseDriveEnable == $past(regWrData[algo_cfg_pkg::BIT_REVERSE_DRIVE_EN], 2))
        else $error("reverse enable not following bit");

    // resync enable follows its written bit two edges after the write
    a_resync_enable: assert property (@(posedge clk) disable iff (!rst_n)
        regWrite && regAddr == algo_cfg_pkg::OFS_DETECT_CFG
        |=> ##1 forwardResyncEnable == $past(regWrData[algo_cfg_pkg::BIT_FORWARD_FORWARD_RESYNC_ENABLE], 2))
        else $error("resync enable not following bit");

    // brake method follows its written bit two edges after the write
    a_brake_method: assert property (@(posedge clk) disable iff (!rst_n)
        regWrite && regAddr == algo_cfg_pkg::OFS_DETECT_CFG
        |=> ##1 brakeAllLowSide == $past(regWrData[algo_cfg_pkg::BIT_BRAKE_METHOD], 2))
        else $error("brake method not following bit");

    // levels mirror storage one edge late at all times, reset release included
    a_detect_level: assert property (@(posedge clk) disable iff (!rst_n)
        speedDetectEnable == $past(detectWord[algo_cfg_pkg::BIT_SPEED_DETECT_EN]))
        else $error("detect enable level wrong");

    // brake permission level against stored bit
    a_brake_level: assert property (@(posedge clk) disable iff (!rst_n)
        detectBrakeEnable == $past(detectWord[algo_cfg_pkg::BIT_DETECT_BRAKE_EN]))
        else $error("brake enable level wrong");

    // coast permission level against stored bit
    a_coast_level: assert property (@(posedge clk) disable iff (!rst_n)
        detectCoastEnable == $past(detectWord[algo_cfg_pkg::BIT_DETECT_COAST_EN]))
        else $error("coast enable level wrong");

    // reverse drive permission level against stored bit
    a_reverse_level: assert property (@(posedge clk) disable iff (!rst_n)
        reverseDriveEnable == $past(detectWord[algo_cfg_pkg::BIT_REVERSE_DRIVE_EN]))
        else $error("reverse enable level wrong");

    // resync permission level against stored bit
    a_resync_level: assert property (@(posedge clk) disable iff (!rst_n)
        forwardResyncEnable == $past(detectWord[algo_cfg_pkg::BIT_FORWARD_FORWARD_RESYNC_ENABLE]))
        else $error("resync enable level wrong");

    // brake method level against stored bit
    a_method_level: assert property (@(posedge clk) disable iff (!rst_n)
        brakeAllLowSide == $past(detectWord[algo_cfg_pkg::BIT_BRAKE_METHOD]))
        else $error("brake method level wrong");

    // an unmapped read is flagged and answers zero, never stale data
    a_unmapped_error: assert property (@(posedge clk) disable iff (!rst_n)
        regRead && !anyHit |=> regAddrError && regRdData == algo_cfg_pkg::READ_ZERO)
        else $error("unmapped read not flagged");

    // an unmapped write is flagged and leaves every stored word as it was
    a_refused_write: assert property (@(posedge clk) disable iff (!rst_n)
        regWrite && !anyHit |=> regAddrError && $stable(values))
        else $error("unmapped write changed storage");
endmodule // motor_algorithm_config_regs

// ===== tb/cfg_host_model.sv
// partner model: register host that drives the bank's access port
`timescale 1ns/1ps
module cfg_host_model
(
    input  wire logic        clk,
    output logic             regWrite,
    output logic             regRead,
    output logic [11:0]      regAddr,
    output logic [31:0]      regWrData,
    input  wire logic [31:0] regRdData,
    input  wire logic        regRdValid,
    input  wire logic        regAddrError
);
    // idle port at time zero, no request before reset is released
    initial
    begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 12'h000;
        regWrData = 32'h0000_0000;
    end

    // one access: request held over one taking edge, answer read at the next settled point
    // the host keeps to listed offsets unless the bench asks for a refused access
    task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] rd, output logic v, output logic e);
        @(posedge clk);
        #1;
        regWrite = wr;
        regRead = !wr;
        regAddr = a;
        regWrData = d;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWrData = ~d; // released data never shows the last value
        rd = regRdData;
        v = regRdValid;
        e = regAddrError;
    endtask
endmodule // cfg_host_model

// ===== tb/tb_motor_algorithm_config_regs.sv
// testbench: checks the configuration bank against a 14-word register model with a queue of answers
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); nMismatch++; end end
module tb_motor_algorithm_config_regs;
    logic        clk;
    logic        rst_n;
    logic        regWrite;
    logic        regRead;
    logic [11:0] regAddr;
    logic [31:0] regWrData;
    logic [31:0] regRdData;
    logic        regRdValid;
    logic        regAddrError;
    logic [5:0]  ctl;
    logic [31:0] mem [14];
    int          nMismatch;
    int          checkCount;
    logic [31:0] expQ [$];
    int          seed;
    int          bl [6] = '{30, 29, 28, 27, 26, 21};
    logic [11:0] bad [6] = '{12'h081, 12'h090, 12'h092, 12'h07E, 12'h0A0, 12'h000};

    cfg_host_model host (.clk(clk), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .regAddrError(regAddrError));

    motor_algorithm_config_regs dut (.clk(clk), .rst_n(rst_n), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid), .regAddrError(regAddrError),
        .speedDetectEnable(ctl[5]), .detectBrakeEnable(ctl[4]),
        .detectCoastEnable(ctl[3]), .reverseDriveEnable(ctl[2]),
        .forwardResyncEnable(ctl[1]), .brakeAllLowSide(ctl[0]));

    // ****************************************
    // model and checks
    // ****************************************
    function automatic int idx(input logic [11:0] a);
        idx = -1;
        for (int i = 0; i < 14; i++)
            if (algo_cfg_pkg::REG_OFFSETS[i] === a)
                idx = i;
    endfunction

    // every access is compared; the model updates only after the answer is judged
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int          i;
        logic [31:0] rd;
        logic        v;
        logic        e;
        logic [31:0] ex;
        i = idx(a);
        expQ.push_back((!wr && i >= 0) ? mem[i] : 32'h0000_0000); // writes answer zero data
        host.access(wr, a, d, rd, v, e);
        ex = expQ.pop_front();
        `CHK("read data", ex, rd)
        `CHK("read valid", !wr, v)
        `CHK("address error", i < 0, e)
        if (wr && i >= 0)
            mem[i] = (i == 0) ? (d & 32'h7FFF_FFFF) : d; // top bit of detect word drops
    endtask

    // control levels lag the detect word by one cycle, so look one edge later
    task automatic chk_ctl();
        @(posedge clk);
        #1;
        `CHK("control outputs", {mem[0][30:26], mem[0][21]}, ctl)
    endtask

    task automatic read_all();
        for (int i = 0; i < 14; i++)
            xfer(1'b0, algo_cfg_pkg::REG_OFFSETS[i], 32'h0000_0000);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ****************************************
    // clock, watchdog and main sequence
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // a hang counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge clk);
        nMismatch++;
        complete_run();
    end

    initial
    begin
        seed = 32'h1e3e;
        nMismatch = 0;
        checkCount = 0;
        rst_n = 1'b0;
        foreach (mem[i]) mem[i] = 32'h0000_0000;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        read_all();
        chk_ctl();
        for (int i = 0; i < 14; i++)
            xfer(1'b1, algo_cfg_pkg::REG_OFFSETS[i], $random(seed) | 32'h8000_0000);
        read_all();
        chk_ctl();
        // each enable alone, then all ones, then all clear
        for (int b = 0; b < 8; b++)
        begin
            xfer(1'b1, 12'h080, (b < 6) ? (32'h1 << bl[b]) : ((b == 6) ? 32'hFFFF_FFFF : 32'h0));
            chk_ctl();
            xfer(1'b0, 12'h080, 32'h0000_0000);
        end
        // refused accesses leave every register as it was
        foreach (bad[j])
        begin
            xfer(1'b1, bad[j], $random(seed));
            xfer(1'b0, bad[j], 32'h0000_0000);
        end
        read_all();
        // second reset in mid-run clears everything again
        xfer(1'b1, 12'h080, $random(seed));
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        foreach (mem[i]) mem[i] = 32'h0000_0000;
        read_all();
        chk_ctl();
        complete_run();
    end
endmodule // tb_motor_algorithm_config_regs
